// >>> flag_bank_pkg.sv
package flag_bank_pkg;

    // Register port geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // Flag register offsets on the special-function register port
    localparam logic [7:0] SECURITY_IRQ_FLAGS_OFS   = 8'h98;
    localparam logic [7:0] RADIO_IRQ_FLAGS_OFS      = 8'h9b;
    localparam logic [7:0] TIMER_PORT_IRQ_FLAGS_OFS = 8'hc0;

    // Event status and mask registers of the interrupt output
    localparam logic [7:0] EVT_STATUS_OFS = 8'hf0;
    localparam logic [7:0] EVT_MASK_OFS   = 8'hf1;

    // Reset values
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] RDATA_IDLE  = 8'h00;

    // Paired flag positions in the security and radio registers
    localparam int unsigned PAIR_HI_BIT = 1;
    localparam int unsigned PAIR_LO_BIT = 0;
    localparam logic [7:0]  PAIR_MASK   = 8'h03;

    // Field positions in the timer and port register
    localparam int unsigned SLEEP_TIMER_BIT = 7;
    localparam int unsigned RESERVED_BIT    = 6;
    localparam int unsigned PORT_ZERO_BIT   = 5;
    localparam int unsigned TIMER_FOUR_BIT  = 4;

    // Interrupt sources, one event line each
    localparam int unsigned NUM_SRC    = 5;
    localparam int unsigned SRC_SEC    = 0;
    localparam int unsigned SRC_RADIO  = 1;
    localparam int unsigned SRC_SLEEP  = 2;
    localparam int unsigned SRC_PORT0  = 3;
    localparam int unsigned SRC_TIMER4 = 4;
    localparam logic [NUM_SRC-1:0] SRC_RESET = 5'h00;

endpackage

// >>> pending_flag.sv
`timescale 1ns/1ns
// One byte of pending flags: software write, hardware set and clear
module pending_flag #(
    parameter int unsigned W = 8
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    input  wire logic [W-1:0] hw_set,
    input  wire logic [W-1:0] hw_clr,
    output logic      [W-1:0] q,
    output logic      [W-1:0] q_nxt
);

    logic [W-1:0] base;

    // Write lands first, then clear, then set so an event is never lost
    assign base  = wr_en ? wr_data : q;
    assign q_nxt = (base & ~hw_clr) | hw_set;

    // Flag storage, all zero after reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= q_nxt;
        end
    end

endmodule

// >>> event_irq_bank.sv
`timescale 1ns/1ns
// Sticky event status, write one to clear, with mask and level output
module event_irq_bank #(
    parameter int unsigned N = 5
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [N-1:0] evt,
    input  wire logic         stat_wr,
    input  wire logic         mask_wr,
    input  wire logic [N-1:0] wr_data,
    output logic      [N-1:0] status_r,
    output logic      [N-1:0] mask_r,
    output logic              irq_r
);

    logic [N-1:0] status_nxt;
    logic [N-1:0] clr;

    // Set wins over a clear in the same cycle
    assign clr        = stat_wr ? wr_data : '0;
    assign status_nxt = (status_r & ~clr) | evt;

    // Status, mask and registered interrupt level
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            status_r <= '0;
            mask_r   <= '0;
            irq_r    <= 1'b0;
        end else begin
            status_r <= status_nxt;
            mask_r   <= mask_wr ? wr_data : mask_r;
            irq_r    <= |(status_nxt & (mask_wr ? wr_data : mask_r));
        end
    end

endmodule

// >>> cpu_interrupt_flag_bank.sv
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
// Functional notes
// - Security event sets both pair bits together
// - Software setting either pair bit requests
// - Radio event sets both pair bits together
// - Unused upper bits hold zero after reset
// - Flag one means pending, resets zero
// - Bit 7 is sleep timer flag, RW
// - Bit 5 is port zero flag, RW
// - Timer four sets bit 4, vector clears
// - Flags set regardless of enable state
// - Module flag clear rechecks, may reassert
module cpu_interrupt_flag_bank (
    // Clock, reset and register port
    input  wire logic                                  core_clk,
    input  wire logic                                  rst_n,
    input  wire logic [flag_bank_pkg::ADDR_W-1:0]      reg_addr,
    input  wire logic [flag_bank_pkg::DATA_W-1:0]      reg_wdata,
    input  wire logic                                  reg_wr,
    input  wire logic                                  reg_rd,
    output logic      [flag_bank_pkg::DATA_W-1:0]      reg_rdata,
    // Events from the peripheral sources
    input  wire logic                                  sec_evt,
    input  wire logic                                  radio_evt,
    input  wire logic                                  sleep_evt,
    input  wire logic                                  port0_evt,
    input  wire logic                                  timer4_evt,
    // Acknowledge and recheck signals from the core
    input  wire logic                                  timer4_vector_ack,
    input  wire logic [flag_bank_pkg::NUM_SRC-1:0]     module_clr,
    input  wire logic [flag_bank_pkg::NUM_SRC-1:0]     module_pend,
    // Requests to the core and the level interrupt
    output logic                                       security_req,
    output logic                                       radio_req,
    output logic                                       sleep_req,
    output logic                                       port0_req,
    output logic                                       timer4_req,
    output logic                                       reserved_set,
    output logic                                       irq
);

    // Short local names for the byte width and the source count; the source
    // count sizes the per-source event vectors, the event status and mask, never the flag bytes
    localparam int unsigned DW = flag_bank_pkg::DATA_W;
    localparam int unsigned NS = flag_bank_pkg::NUM_SRC;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    // Per-source event vectors, indexed by the source numbers
    logic [NS-1:0] src_evt;
    logic [NS-1:0] recheck_evt;
    logic [NS-1:0] set_evt;

    // Register selects, one hot for a mapped address
    logic          sel_sec;
    logic          sel_radio;
    logic          sel_tp;
    logic          sel_stat;
    logic          sel_mask;
    logic          sel_any;

    // Write strobes gated by their select
    logic          wr_sec;
    logic          wr_radio;
    logic          wr_tp;
    logic          wr_stat;
    logic          wr_mask;

    // Hardware set and clear bytes
    logic [DW-1:0] sec_set;
    logic [DW-1:0] radio_set;
    logic [DW-1:0] tp_set;
    logic [DW-1:0] tp_clr;

    // Flag bytes and their next values
    logic [DW-1:0] sec_q;
    logic [DW-1:0] sec_nxt;
    logic [DW-1:0] radio_q;
    logic [DW-1:0] radio_nxt;
    logic [DW-1:0] tp_q;
    logic [DW-1:0] tp_nxt;

    // Event status, mask and interrupt level
    logic [NS-1:0] evt_status;
    logic [NS-1:0] evt_mask;
    logic          irq_level;

    // Read selection
    logic [DW-1:0] rd_mux;
    logic [DW-1:0] rdata_nxt;

    // Output flip-flops; every top output but irq leaves from one of these
    logic [DW-1:0] rdata_r;
    logic          security_req_r;
    logic          radio_req_r;
    logic          sleep_req_r;
    logic          port0_req_r;
    logic          timer4_req_r;
    logic          reserved_set_r;

    ////////////////////////////////////////////////////////////////////////////
    // Event gathering

    // Sources are logic on core_clk, so no synchroniser stands in front.
    // Each high cycle counts as one event; a source that holds its line
    // high simply keeps setting a flag that is already set.
    // Source events, one line per interrupt source
    assign src_evt[flag_bank_pkg::SRC_SEC]    = sec_evt;
    assign src_evt[flag_bank_pkg::SRC_RADIO]  = radio_evt;
    assign src_evt[flag_bank_pkg::SRC_SLEEP]  = sleep_evt;
    assign src_evt[flag_bank_pkg::SRC_PORT0]  = port0_evt;
    assign src_evt[flag_bank_pkg::SRC_TIMER4] = timer4_evt;

    // Module flag cleared while others still enabled and set: raise again
    // The peripheral reports that it has more work through module_pend,
    // so a lost request after a partial clear cannot happen here.
    assign recheck_evt = module_clr & module_pend;

    // Hazard: gating the set by the enable would lose an event that arrives
    // while software has the source masked, so the flag is always taken.
    // Enables play no part here; gating is done further on by the core
    assign set_evt = src_evt | recheck_evt;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    // Full eight-bit compare: the register space is dense, so a partial
    // decode would alias these bytes onto their neighbours.
    // Exact byte decode; anything else is unmapped
    assign sel_sec   = (reg_addr == flag_bank_pkg::SECURITY_IRQ_FLAGS_OFS);
    assign sel_radio = (reg_addr == flag_bank_pkg::RADIO_IRQ_FLAGS_OFS);
    assign sel_tp    = (reg_addr == flag_bank_pkg::TIMER_PORT_IRQ_FLAGS_OFS);
    assign sel_stat  = (reg_addr == flag_bank_pkg::EVT_STATUS_OFS);
    assign sel_mask  = (reg_addr == flag_bank_pkg::EVT_MASK_OFS);
    assign sel_any   = sel_sec | sel_radio | sel_tp | sel_stat | sel_mask;

    // Writes to the status and mask bytes serve the level interrupt only
    // and leave the flag bytes alone.
    // Whole-byte write strobes, no partial lanes on this port
    assign wr_sec   = reg_wr & sel_sec;
    assign wr_radio = reg_wr & sel_radio;
    assign wr_tp    = reg_wr & sel_tp;
    assign wr_stat  = reg_wr & sel_stat;
    assign wr_mask  = reg_wr & sel_mask;

    ////////////////////////////////////////////////////////////////////////////
    // Hardware set and clear vectors

    // A recheck after a module-level clear counts as a fresh event, so it
    // fills a pair completely, just as the source itself would.
    // Security event fills both flags of its pair at once
    assign sec_set = set_evt[flag_bank_pkg::SRC_SEC] ? flag_bank_pkg::PAIR_MASK
                                                      : flag_bank_pkg::FLAGS_RESET;

    // Radio event fills both flags of its pair at once
    assign radio_set = set_evt[flag_bank_pkg::SRC_RADIO] ? flag_bank_pkg::PAIR_MASK
                                                          : flag_bank_pkg::FLAGS_RESET;

    // Reserved bit 6 and bits 3:0 get no hardware set at all; only software
    // can change them.
    // Sleep timer, port zero and timer four events each own one bit
    always_comb begin
        tp_set = flag_bank_pkg::FLAGS_RESET;
        tp_set[flag_bank_pkg::SLEEP_TIMER_BIT] = set_evt[flag_bank_pkg::SRC_SLEEP];
        tp_set[flag_bank_pkg::PORT_ZERO_BIT]   = set_evt[flag_bank_pkg::SRC_PORT0];
        tp_set[flag_bank_pkg::TIMER_FOUR_BIT]  = set_evt[flag_bank_pkg::SRC_TIMER4];
    end

    // Sleep timer and port zero flags are cleared by software only; the
    // acknowledge from the core is wired to the timer four bit alone.
    // Only the timer four flag is cleared by the vector acknowledge
    // A fresh timer event in the acknowledge cycle still wins.
    always_comb begin
        tp_clr = flag_bank_pkg::FLAGS_RESET;
        tp_clr[flag_bank_pkg::TIMER_FOUR_BIT] = timer4_vector_ack;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flag registers

    // All three bytes use one flag cell. Inside it a software write loads
    // the byte first, the hardware clear comes next and the hardware set
    // last, so an event that meets a write or an acknowledge is never lost.
    // Limitation: software cannot clear a flag in the cycle its event fires.
    // Security pair; bits 7:2 are plain storage that hardware never sets
    pending_flag #(
        .W       (DW)
    ) u_sec_flags (
        .core_clk(core_clk),
        .rst_n   (rst_n),
        .wr_en   (wr_sec),
        .wr_data (reg_wdata),
        .hw_set  (sec_set),
        .hw_clr  (flag_bank_pkg::FLAGS_RESET),
        .q       (sec_q),
        .q_nxt   (sec_nxt)
    );

    // Radio pair; upper bits likewise left to software
    pending_flag #(
        .W       (DW)
    ) u_radio_flags (
        .core_clk(core_clk),
        .rst_n   (rst_n),
        .wr_en   (wr_radio),
        .wr_data (reg_wdata),
        .hw_set  (radio_set),
        .hw_clr  (flag_bank_pkg::FLAGS_RESET),
        .q       (radio_q),
        .q_nxt   (radio_nxt)
    );

    // Timer and port flags; reserved bit 6 is stored as written
    pending_flag #(
        .W       (DW)
    ) u_tp_flags (
        .core_clk(core_clk),
        .rst_n   (rst_n),
        .wr_en   (wr_tp),
        .wr_data (reg_wdata),
        .hw_set  (tp_set),
        .hw_clr  (tp_clr),
        .q       (tp_q),
        .q_nxt   (tp_nxt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Requests to the core

    // Trade-off: one more flip-flop per request buys outputs that leave
    // straight from a register, at no cost in latency, because the next
    // flag value rather than the stored one feeds them.
    // Requests follow the next flag value so they line up with the flags.
    // Either half of a pair is enough, so a one-bit software set works.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            security_req_r <= 1'b0;
            radio_req_r    <= 1'b0;
            sleep_req_r    <= 1'b0;
            port0_req_r    <= 1'b0;
            timer4_req_r   <= 1'b0;
            reserved_set_r <= 1'b0;
        end else begin
            security_req_r <= sec_nxt[flag_bank_pkg::PAIR_HI_BIT]
                            | sec_nxt[flag_bank_pkg::PAIR_LO_BIT];
            radio_req_r    <= radio_nxt[flag_bank_pkg::PAIR_HI_BIT]
                            | radio_nxt[flag_bank_pkg::PAIR_LO_BIT];
            sleep_req_r    <= tp_nxt[flag_bank_pkg::SLEEP_TIMER_BIT];
            port0_req_r    <= tp_nxt[flag_bank_pkg::PORT_ZERO_BIT];
            timer4_req_r   <= tp_nxt[flag_bank_pkg::TIMER_FOUR_BIT];
            reserved_set_r <= tp_nxt[flag_bank_pkg::RESERVED_BIT];
        end
    end

    // Software that leaves the reserved bit set makes the core re-enter its
    // service routine without end; the block reports this, it does not fix it.
    // A set reserved bit is only flagged; the block does not force it back
    assign reserved_set = reserved_set_r;
    assign security_req = security_req_r;
    assign radio_req    = radio_req_r;
    assign sleep_req    = sleep_req_r;
    assign port0_req    = port0_req_r;
    assign timer4_req   = timer4_req_r;

    ////////////////////////////////////////////////////////////////////////////
    // Event status and interrupt output

    // The status byte is separate from the flag bytes: clearing a flag does
    // not clear its status bit, and the reverse holds too. Software that
    // uses the level interrupt clears both. Status bits sit at the source
    // numbers: 0 security, 1 radio, 2 sleep timer, 3 port zero, 4 timer four.
    // Every flag-setting event is also logged for the interrupt line
    event_irq_bank #(
        .N       (NS)
    ) u_evt_irq (
        .core_clk(core_clk),
        .rst_n   (rst_n),
        .evt     (set_evt),
        .stat_wr (wr_stat),
        .mask_wr (wr_mask),
        .wr_data (reg_wdata[NS-1:0]),
        .status_r(evt_status),
        .mask_r  (evt_mask),
        .irq_r   (irq_level)
    );

    // Level output, already registered inside the bank
    assign irq = irq_level;

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    // Reads have no side effect on any flag, so polling is safe.
    // Read mux; status and mask sit in the low bits, upper bits zero
    assign rd_mux = sel_sec   ? sec_q :
                    sel_radio ? radio_q :
                    sel_tp    ? tp_q :
                    sel_stat  ? {{(DW-NS){1'b0}}, evt_status} :
                    sel_mask  ? {{(DW-NS){1'b0}}, evt_mask} :
                                flag_bank_pkg::RDATA_IDLE;

    // Data stands for the one cycle after the strobe, zero otherwise
    assign rdata_nxt = (reg_rd && sel_any) ? rd_mux : flag_bank_pkg::RDATA_IDLE;

    // Read data register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_r <= flag_bank_pkg::RDATA_IDLE;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Read data leaves from the read data flip-flop
    assign reg_rdata = rdata_r;

endmodule

// >>> flag_bank_asserts.sv
`timescale 1ns/1ns
module flag_bank_checker (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       sec_evt,
    input wire logic       radio_evt,
    input wire logic       sleep_evt,
    input wire logic       port0_evt,
    input wire logic       timer4_evt,
    input wire logic       timer4_vector_ack,
    input wire logic [4:0] module_clr,
    input wire logic [4:0] module_pend,
    input wire logic       security_req,
    input wire logic       radio_req,
    input wire logic       sleep_req,
    input wire logic       port0_req,
    input wire logic       timer4_req,
    input wire logic       reserved_set,
    input wire logic       irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    // Software write touching the security pair
    sequence s_pair_wr;
        reg_wr && reg_addr == flag_bank_pkg::SECURITY_IRQ_FLAGS_OFS
            && (reg_wdata & flag_bank_pkg::PAIR_MASK) != 8'h00;
    endsequence
    // Vector ack with nothing that could set the flag again
    sequence s_clean_ack;
        timer4_vector_ack && !timer4_evt && !(module_clr[4] && module_pend[4])
            && !(reg_wr && reg_addr == flag_bank_pkg::TIMER_PORT_IRQ_FLAGS_OFS);
    endsequence
    ////////////////////////////////////////
    // Each source shows on its request one cycle later
    a_sec_pair_set: assert property (sec_evt |=> security_req)
        else $error("security event did not raise request");
    a_radio_pair_set: assert property (radio_evt |=> radio_req)
        else $error("radio event did not raise request");
    a_sleep_flag_set: assert property (sleep_evt |=> sleep_req)
        else $error("sleep event did not raise request");
    a_port_flag_set: assert property (port0_evt |=> port0_req)
        else $error("port event did not raise request");
    a_timer_flag_set: assert property (timer4_evt |=> timer4_req)
        else $error("timer event did not raise request");
    a_timer_ack_clear: assert property (s_clean_ack |=> !timer4_req)
        else $error("vector ack left timer flag set");
    a_sw_pair_req: assert property (s_pair_wr |=> security_req)
        else $error("single pair bit write gave no request");
    a_recheck_reassert: assert property (module_clr[1] && module_pend[1] |=> radio_req)
        else $error("recheck did not reassert radio flag");
    a_reserved_echo: assert property (reg_wr && reg_addr == 8'hc0
        |=> reserved_set == $past(reg_wdata[6]))
        else $error("reserved bit not reported as written");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
endmodule
bind cpu_interrupt_flag_bank flag_bank_checker flag_bank_checker_i (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sec_evt(sec_evt),
    .radio_evt(radio_evt), .sleep_evt(sleep_evt), .port0_evt(port0_evt),
    .timer4_evt(timer4_evt), .timer4_vector_ack(timer4_vector_ack),
    .module_clr(module_clr), .module_pend(module_pend), .security_req(security_req),
    .radio_req(radio_req), .sleep_req(sleep_req), .port0_req(port0_req),
    .timer4_req(timer4_req), .reserved_set(reserved_set), .irq(irq));

// >>> evt_src_model.sv
`timescale 1ns/1ns
module evt_src_model (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       slow,
    input  wire logic [5:0] fire,
    output logic      [5:0] pulse
);
    logic [5:0] stage_r;
    // Sources answer one or two cycles late; the slow path is a lagging peripheral
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stage_r <= 6'h00;
            pulse   <= 6'h00;
        end else begin
            stage_r <= fire;
            pulse   <= slow ? stage_r : fire; // One high cycle is one event
        end
    end
endmodule

// >>> tb.sv
`timescale 1ns/1ns
module tb;
    logic       core_clk, rst_n, reg_wr, reg_rd, slow;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [4:0] module_clr, module_pend;
    logic [5:0] fire, pulse;
    logic       security_req, radio_req, sleep_req, port0_req, timer4_req, reserved_set, irq;
    int         bad_count, checks;
    logic [7:0] map_a [5] = '{8'h98, 8'h9b, 8'hc0, 8'hf0, 8'hf1};
    cpu_interrupt_flag_bank cpu_interrupt_flag_bank_i (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sec_evt(pulse[0]),
        .radio_evt(pulse[1]), .sleep_evt(pulse[2]), .port0_evt(pulse[3]),
        .timer4_evt(pulse[4]), .timer4_vector_ack(pulse[5]), .module_clr(module_clr),
        .module_pend(module_pend), .security_req(security_req), .radio_req(radio_req),
        .sleep_req(sleep_req), .port0_req(port0_req), .timer4_req(timer4_req),
        .reserved_set(reserved_set), .irq(irq));
    evt_src_model evt_src_model_i (
        .core_clk(core_clk), .rst_n(rst_n), .slow(slow), .fire(fire), .pulse(pulse));
    ////////////////////////////////////////
    // Clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        bad_count++;
        finish_test;
    end
    task finish_test;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Byte accesses; each leaves the bench at a falling edge
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(negedge core_clk);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk(reg_rdata, exp);
    endtask
    // Request events from the source model and wait until taken
    task evt(input logic [5:0] m);
        @(posedge core_clk);
        fire <= m;
        @(posedge core_clk);
        fire <= 6'h00;
        @(posedge core_clk);
        @(negedge core_clk);
    endtask
    ////////////////////////////////////////
    initial begin
        {rst_n, reg_wr, reg_rd, slow, reg_addr, reg_wdata} = '0;
        {module_clr, module_pend, fire, bad_count, checks} = '0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (map_a[i]) rd(map_a[i], 8'h00);
        // Sources set flags while everything is masked
        evt(6'h03);
        rd(8'h98, 8'h03);
        rd(8'h9b, 8'h03);
        chk({7'h0, irq}, 8'h00);
        evt(6'h1c);
        rd(8'hc0, 8'hb0);
        evt(6'h20);
        rd(8'hc0, 8'ha0);
        // Software clears the pairs, then sets one bit of each
        wr(8'h98, 8'h00);
        wr(8'h9b, 8'h00);
        chk({6'h0, security_req, radio_req}, 8'h00);
        wr(8'h98, 8'h02);
        wr(8'h9b, 8'h01);
        chk({6'h0, security_req, radio_req}, 8'h03);
        wr(8'hc0, 8'h40);
        chk({7'h0, reserved_set}, 8'h01);
        wr(8'hc0, 8'ha0);
        chk({4'h0, sleep_req, reserved_set, port0_req, timer4_req}, 8'h0a);
        wr(8'hc0, 8'h00);
        chk({4'h0, sleep_req, reserved_set, port0_req, timer4_req}, 8'h00);
        // Timer event in the acknowledge cycle; the set must win
        evt(6'h30);
        chk({7'h0, timer4_req}, 8'h01);
        // Late source lands on the same edge as a software clear; the set must win
        @(posedge core_clk);
        slow <= 1'b1;
        fire <= 6'h01;
        @(posedge core_clk);
        fire <= 6'h00;
        wr(8'h98, 8'h00);
        rd(8'h98, 8'h03);
        @(posedge core_clk);
        slow <= 1'b0;
        // Module clear reasserts only with a flag still pending
        wr(8'h9b, 8'h00);
        @(posedge core_clk);
        module_clr <= 5'h02;
        @(posedge core_clk);
        module_pend <= 5'h02;
        @(negedge core_clk);
        chk({7'h0, radio_req}, 8'h00);
        @(posedge core_clk);
        {module_clr, module_pend} <= '0;
        @(negedge core_clk);
        chk({7'h0, radio_req}, 8'h01);
        // Interrupt output: unmask, clear by writing one, raise again
        wr(8'hf1, 8'h01);
        rd(8'hf1, 8'h01);
        chk({7'h0, irq}, 8'h01);
        wr(8'hf0, 8'h01);
        rd(8'hf0, 8'h1e);
        chk({7'h0, irq}, 8'h00);
        wr(8'hf0, 8'h1e);
        rd(8'hf0, 8'h00);
        evt(6'h01);
        chk({7'h0, irq}, 8'h01);
        // Unmapped place, and read data standing one cycle only
        wr(8'h55, 8'hff);
        rd(8'h55, 8'h00);
        rd(8'h98, 8'h03);
        @(negedge core_clk);
        chk(reg_rdata, 8'h00);
        // Recheck on the other sources, then a reset in mid-run clears all
        wr(8'h98, 8'h00);
        @(posedge core_clk);
        {module_clr, module_pend} <= {5'h1d, 5'h1d};
        @(posedge core_clk);
        {module_clr, module_pend} <= '0;
        @(negedge core_clk);
        chk({4'h0, sleep_req, security_req, port0_req, timer4_req}, 8'h0f);
        rd(8'hc0, 8'hb0);
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (map_a[i]) rd(map_a[i], 8'h00);
        chk({6'h0, security_req, irq}, 8'h00);
        finish_test;
    end
endmodule
